// File: logic/hbp_pkg.sv
// Shared constants for the half-bridge PWM gate controller.
package hbp_pkg;

	// APB register byte offsets
	localparam logic [7:0] HBP_OFS_CTRL = 8'h00;
	localparam logic [7:0] HBP_OFS_ACT_TIME = 8'h04;
	localparam logic [7:0] HBP_OFS_FW_TIME = 8'h08;
	localparam logic [7:0] HBP_OFS_CHG = 8'h0C;
	localparam logic [7:0] HBP_OFS_DCHG = 8'h10;
	localparam logic [7:0] HBP_OFS_INIT = 8'h14;
	localparam logic [7:0] HBP_OFS_STATUS = 8'h18;
	localparam logic [7:0] HBP_OFS_ON_TIME = 8'h1C;
	localparam logic [7:0] HBP_OFS_OFF_TIME = 8'h20;
	localparam logic [7:0] HBP_OFS_NOMINAL = 8'h24;

	// Control register fields
	localparam int HBP_CTRL_BANK = 0;
	localparam int HBP_CTRL_GEN_EN = 1;
	localparam int HBP_CTRL_MODE_LO = 2;
	localparam int HBP_CTRL_MODE_HI = 3;

	// Code fields: charge in [4:0], discharge in [12:8]
	localparam int HBP_CHG_LO = 0;
	localparam int HBP_CHG_HI = 4;
	localparam int HBP_DCHG_LO = 8;
	localparam int HBP_DCHG_HI = 12;
	localparam int HBP_NOM_DCHG_LO = 16;

	// Widths
	localparam int HBP_CODE_W = 5;
	localparam int HBP_TIME_W = 8;
	localparam int HBP_CNT_W = 16;
	localparam int HBP_NOM_W = 10;
	localparam int HBP_DEPTH = 256;

	// Reset values
	localparam logic [HBP_TIME_W-1:0] HBP_RST_TIME = 8'h19;
	localparam logic [HBP_CODE_W-1:0] HBP_RST_CODE = 5'h08;
	localparam logic [1:0] HBP_RST_MODE = 2'h0;

	// Half-bridge mode encodings
	localparam logic [1:0] HBP_MODE_OFF = 2'h0;
	localparam logic [1:0] HBP_MODE_HS_PWM = 2'h1;
	localparam logic [1:0] HBP_MODE_LS_PWM = 2'h2;

	// Clock: 25 MHz
	localparam int HBP_CLK_PERIOD_NS = 40;

	typedef enum logic [1:0] {
		HBP_CASE_LOAD = 2'b00,
		HBP_CASE_GEN = 2'b01,
		HBP_CASE_HIGH = 2'b10,
		HBP_CASE_LOW = 2'b11
	} hbp_case_t;

endpackage

// File: logic/hbp_delay_mem.sv
// Single-bit delay line memory with two registered read ports.
module hbp_delay_mem (
	input wire logic clk_sys,
	input wire logic [hbp_pkg::HBP_TIME_W-1:0] wr_addr,
	input wire logic wr_data,
	input wire logic [hbp_pkg::HBP_TIME_W-1:0] rd_addr_a,
	input wire logic [hbp_pkg::HBP_TIME_W-1:0] rd_addr_b,
	output logic rd_data_a,
	output logic rd_data_b
);
	import hbp_pkg::*;

	logic mem_r [HBP_DEPTH];

	////////////////////////////////////////////////////////////////////////
	// Write every cycle, read through output registers
	always_ff @(posedge clk_sys) begin
		mem_r[wr_addr] <= wr_data;
		rd_data_a <= mem_r[rd_addr_a];
		rd_data_b <= mem_r[rd_addr_b];
	end

endmodule

// File: logic/hbp_gate_ctrl.sv
// Half-bridge PWM gate command and gate current code controller.
//
// The register addresses and the APB interface to the registers are this design's own decisions.
module hbp_gate_ctrl (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic pwm_in,
	input wire logic generator_sense,
	output logic gate_hs_on,
	output logic gate_ls_on,
	output logic [hbp_pkg::HBP_CODE_W-1:0] hs_charge_code,
	output logic [hbp_pkg::HBP_CODE_W-1:0] hs_discharge_code,
	output logic [hbp_pkg::HBP_CODE_W-1:0] ls_charge_code,
	output logic [hbp_pkg::HBP_CODE_W-1:0] ls_discharge_code,
	output logic [hbp_pkg::HBP_CODE_W-1:0] precharge_initial_code,
	output logic [hbp_pkg::HBP_CODE_W-1:0] predischarge_initial_code,
	output logic switch_timing_valid
);
	import hbp_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Functions

	// Zero delay would read the slot being written; clamp to one
	function automatic logic [HBP_TIME_W-1:0] eff_delay(
		input logic [HBP_TIME_W-1:0] d
	);
		eff_delay = (d == '0) ? 8'h01 : d;
	endfunction

	// Nominal charge current in 0.1 mA steps, strictly rising
	function automatic logic [HBP_NOM_W-1:0] charge_nominal(
		input logic [HBP_CODE_W-1:0] c
	);
		case (c)
			5'h00: charge_nominal = 10'h00A;
			5'h01: charge_nominal = 10'h00F;
			5'h02: charge_nominal = 10'h014;
			5'h03: charge_nominal = 10'h020;
			5'h04: charge_nominal = 10'h02D;
			5'h05: charge_nominal = 10'h03F;
			5'h06: charge_nominal = 10'h050;
			5'h07: charge_nominal = 10'h067;
			5'h08: charge_nominal = 10'h07D;
			5'h09: charge_nominal = 10'h097;
			5'h0A: charge_nominal = 10'h0B2;
			5'h0B: charge_nominal = 10'h0D0;
			5'h0C: charge_nominal = 10'h0EF;
			5'h0D: charge_nominal = 10'h10E;
			5'h0E: charge_nominal = 10'h12C;
			5'h0F: charge_nominal = 10'h14F;
			5'h10: charge_nominal = 10'h173;
			5'h11: charge_nominal = 10'h197;
			5'h12: charge_nominal = 10'h1BB;
			5'h13: charge_nominal = 10'h1E3;
			5'h14: charge_nominal = 10'h20B;
			5'h15: charge_nominal = 10'h232;
			5'h16: charge_nominal = 10'h259;
			5'h17: charge_nominal = 10'h282;
			5'h18: charge_nominal = 10'h2AB;
			5'h19: charge_nominal = 10'h2D5;
			5'h1A: charge_nominal = 10'h300;
			5'h1B: charge_nominal = 10'h32E;
			5'h1C: charge_nominal = 10'h35C;
			5'h1D: charge_nominal = 10'h38E;
			5'h1E: charge_nominal = 10'h3C0;
			default: charge_nominal = 10'h3E8;
		endcase
	endfunction

	// Nominal discharge current in 0.1 mA steps, strictly rising
	function automatic logic [HBP_NOM_W-1:0] discharge_nominal(
		input logic [HBP_CODE_W-1:0] c
	);
		case (c)
			5'h00: discharge_nominal = 10'h00A;
			5'h01: discharge_nominal = 10'h013;
			5'h02: discharge_nominal = 10'h01C;
			5'h03: discharge_nominal = 10'h02B;
			5'h04: discharge_nominal = 10'h039;
			5'h05: discharge_nominal = 10'h04B;
			5'h06: discharge_nominal = 10'h05E;
			5'h07: discharge_nominal = 10'h076;
			5'h08: discharge_nominal = 10'h08E;
			5'h09: discharge_nominal = 10'h0AA;
			5'h0A: discharge_nominal = 10'h0C5;
			5'h0B: discharge_nominal = 10'h0E5;
			5'h0C: discharge_nominal = 10'h104;
			5'h0D: discharge_nominal = 10'h122;
			5'h0E: discharge_nominal = 10'h140;
			5'h0F: discharge_nominal = 10'h166;
			5'h10: discharge_nominal = 10'h18B;
			5'h11: discharge_nominal = 10'h1AF;
			5'h12: discharge_nominal = 10'h1D4;
			5'h13: discharge_nominal = 10'h1FC;
			5'h14: discharge_nominal = 10'h223;
			5'h15: discharge_nominal = 10'h24A;
			5'h16: discharge_nominal = 10'h271;
			5'h17: discharge_nominal = 10'h29A;
			5'h18: discharge_nominal = 10'h2C2;
			5'h19: discharge_nominal = 10'h2EA;
			5'h1A: discharge_nominal = 10'h311;
			5'h1B: discharge_nominal = 10'h33C;
			5'h1C: discharge_nominal = 10'h366;
			5'h1D: discharge_nominal = 10'h38E;
			5'h1E: discharge_nominal = 10'h3B6;
			default: discharge_nominal = 10'h3E8;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Declarations
	logic bank_sel_r;
	logic generator_detect_enable_r;
	logic [1:0] halfbridge_mode_select_r;
	logic [HBP_TIME_W-1:0] active_crosscurrent_time_r;
	logic [HBP_TIME_W-1:0] freewheel_crosscurrent_time_r;
	logic [HBP_CODE_W-1:0] active_charge_code_r;
	logic [HBP_CODE_W-1:0] active_discharge_code_r;
	logic [HBP_CODE_W-1:0] freewheel_charge_code_r;
	logic [HBP_CODE_W-1:0] freewheel_discharge_code_r;
	logic [HBP_CODE_W-1:0] precharge_initial_code_r;
	logic [HBP_CODE_W-1:0] predischarge_initial_code_r;
	logic pwm_s1_r;
	logic pwm_s2_r;
	logic pwm_s3_r;
	logic [HBP_CNT_W-1:0] run_cnt_r;
	logic [HBP_CNT_W-1:0] on_time_r;
	logic [HBP_CNT_W-1:0] off_time_r;
	hbp_case_t case_r;
	logic [HBP_TIME_W-1:0] wr_ptr_r;
	logic fill_done_r;
	logic dly_fw;
	logic dly_act;
	logic pwm_mos_on;
	logic opp_mos_on;
	logic pwm_mos_active;
	logic gate_hs_r;
	logic gate_ls_r;
	logic [HBP_CODE_W-1:0] hs_chg_r;
	logic [HBP_CODE_W-1:0] hs_dchg_r;
	logic [HBP_CODE_W-1:0] ls_chg_r;
	logic [HBP_CODE_W-1:0] ls_dchg_r;
	logic [31:0] prdata_r;
	logic pslverr_r;
	logic [31:0] rd_nxt;
	logic map_ok;
	logic wr_en;
	logic setup;
	logic pwm_rise;
	logic pwm_fall;
	logic [HBP_CNT_W-1:0] off_now;

	////////////////////////////////////////////////////////////////////////
	// APB slave: zero wait states, read data captured in setup phase
	assign setup = psel & ~penable;
	assign wr_en = psel & penable & pwrite & map_ok;
	assign pready = psel & penable;
	assign prdata = prdata_r;
	assign pslverr = pslverr_r;

	// Read mux; offsets CHG and DCHG are banked by bank_sel_r
	always_comb begin
		rd_nxt = '0;
		map_ok = 1'b1;
		case (paddr)
			HBP_OFS_CTRL: begin
				rd_nxt[HBP_CTRL_BANK] = bank_sel_r;
				rd_nxt[HBP_CTRL_GEN_EN] = generator_detect_enable_r;
				rd_nxt[HBP_CTRL_MODE_HI:HBP_CTRL_MODE_LO] =
					halfbridge_mode_select_r;
			end
			HBP_OFS_ACT_TIME: rd_nxt[HBP_TIME_W-1:0] = active_crosscurrent_time_r;
			HBP_OFS_FW_TIME: rd_nxt[HBP_TIME_W-1:0] = freewheel_crosscurrent_time_r;
			HBP_OFS_CHG: begin
				if (bank_sel_r) begin
					rd_nxt[HBP_CHG_HI:HBP_CHG_LO] = freewheel_charge_code_r;
					rd_nxt[HBP_DCHG_HI:HBP_DCHG_LO] = freewheel_discharge_code_r;
				end else begin
					rd_nxt[HBP_CHG_HI:HBP_CHG_LO] = active_charge_code_r;
				end
			end
			HBP_OFS_DCHG: begin
				if (!bank_sel_r) begin
					rd_nxt[HBP_CHG_HI:HBP_CHG_LO] = active_discharge_code_r;
				end
			end
			HBP_OFS_INIT: begin
				rd_nxt[HBP_CHG_HI:HBP_CHG_LO] = precharge_initial_code_r;
				rd_nxt[HBP_DCHG_HI:HBP_DCHG_LO] = predischarge_initial_code_r;
			end
			HBP_OFS_STATUS: begin
				rd_nxt[1:0] = case_r;
				rd_nxt[2] = switch_timing_valid;
				rd_nxt[3] = fill_done_r;
			end
			HBP_OFS_ON_TIME: rd_nxt[HBP_CNT_W-1:0] = on_time_r;
			HBP_OFS_OFF_TIME: rd_nxt[HBP_CNT_W-1:0] = off_time_r;
			HBP_OFS_NOMINAL: begin
				rd_nxt[HBP_NOM_W-1:0] = charge_nominal(active_charge_code_r);
				rd_nxt[HBP_NOM_DCHG_LO+HBP_NOM_W-1:HBP_NOM_DCHG_LO] =
					discharge_nominal(active_discharge_code_r);
			end
			default: map_ok = 1'b0;
		endcase
	end

	// Read data and error flag registered at setup, valid in access
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			prdata_r <= '0;
			pslverr_r <= 1'b0;
		end else if (setup) begin
			prdata_r <= pwrite ? 32'h0000_0000 : rd_nxt;
			pslverr_r <= ~map_ok;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control and timing registers
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			bank_sel_r <= 1'b0;
			generator_detect_enable_r <= 1'b0;
			halfbridge_mode_select_r <= HBP_RST_MODE;
			active_crosscurrent_time_r <= HBP_RST_TIME;
			freewheel_crosscurrent_time_r <= HBP_RST_TIME;
		end else if (wr_en && paddr == HBP_OFS_CTRL) begin
			bank_sel_r <= pwdata[HBP_CTRL_BANK];
			generator_detect_enable_r <= pwdata[HBP_CTRL_GEN_EN];
			halfbridge_mode_select_r <=
				pwdata[HBP_CTRL_MODE_HI:HBP_CTRL_MODE_LO];
		end else if (wr_en && paddr == HBP_OFS_ACT_TIME) begin
			active_crosscurrent_time_r <= pwdata[HBP_TIME_W-1:0];
		end else if (wr_en && paddr == HBP_OFS_FW_TIME) begin
			freewheel_crosscurrent_time_r <= pwdata[HBP_TIME_W-1:0];
		end
	end

	// Current code registers; CHG and DCHG writes steered by the bank bit
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			active_charge_code_r <= HBP_RST_CODE;
			active_discharge_code_r <= HBP_RST_CODE;
			freewheel_charge_code_r <= HBP_RST_CODE;
			freewheel_discharge_code_r <= HBP_RST_CODE;
			precharge_initial_code_r <= HBP_RST_CODE;
			predischarge_initial_code_r <= HBP_RST_CODE;
		end else if (wr_en && paddr == HBP_OFS_CHG && !bank_sel_r) begin
			active_charge_code_r <= pwdata[HBP_CHG_HI:HBP_CHG_LO];
		end else if (wr_en && paddr == HBP_OFS_DCHG && !bank_sel_r) begin
			active_discharge_code_r <= pwdata[HBP_CHG_HI:HBP_CHG_LO];
		end else if (wr_en && paddr == HBP_OFS_CHG && bank_sel_r) begin
			freewheel_charge_code_r <= pwdata[HBP_CHG_HI:HBP_CHG_LO];
			freewheel_discharge_code_r <= pwdata[HBP_DCHG_HI:HBP_DCHG_LO];
		end else if (wr_en && paddr == HBP_OFS_INIT) begin
			precharge_initial_code_r <= pwdata[HBP_CHG_HI:HBP_CHG_LO];
			predischarge_initial_code_r <= pwdata[HBP_DCHG_HI:HBP_DCHG_LO];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// PWM input synchroniser; stage 1 feeds only stage 2
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pwm_s1_r <= 1'b0;
			pwm_s2_r <= 1'b0;
			pwm_s3_r <= 1'b0;
		end else begin
			pwm_s1_r <= pwm_in;
			pwm_s2_r <= pwm_s1_r;
			pwm_s3_r <= pwm_s2_r;
		end
	end

	assign pwm_rise = pwm_s2_r & ~pwm_s3_r;
	assign pwm_fall = ~pwm_s2_r & pwm_s3_r;
	assign off_now = run_cnt_r;

	////////////////////////////////////////////////////////////////////////
	// On/off time measurement, saturating at full scale
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			run_cnt_r <= '0;
			on_time_r <= '0;
			off_time_r <= '0;
		end else if (pwm_rise) begin
			off_time_r <= run_cnt_r;
			run_cnt_r <= 16'h0001;
		end else if (pwm_fall) begin
			on_time_r <= run_cnt_r;
			run_cnt_r <= 16'h0001;
		end else if (run_cnt_r != 16'hFFFF) begin
			run_cnt_r <= run_cnt_r + 16'h0001;
		end
	end

	// Case chosen once per period at the rising edge
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			case_r <= HBP_CASE_LOW;
		end else if (pwm_rise) begin
			if (off_now < {8'h00, active_crosscurrent_time_r}) begin
				case_r <= HBP_CASE_HIGH;
			end else if (on_time_r < {8'h00, freewheel_crosscurrent_time_r}) begin
				case_r <= HBP_CASE_LOW;
			end else if (generator_detect_enable_r && generator_sense &&
				off_now > {8'h00, freewheel_crosscurrent_time_r} &&
				on_time_r > {8'h00, active_crosscurrent_time_r}) begin
				case_r <= HBP_CASE_GEN;
			end else begin
				case_r <= HBP_CASE_LOAD;
			end
		end
	end

	// Switching times only meaningful in the general cases
	assign switch_timing_valid =
		(case_r == HBP_CASE_LOAD) || (case_r == HBP_CASE_GEN);

	////////////////////////////////////////////////////////////////////////
	// Delay line; gate off until every slot has been written once
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wr_ptr_r <= '0;
			fill_done_r <= 1'b0;
		end else begin
			wr_ptr_r <= wr_ptr_r + 8'h01;
			if (wr_ptr_r == 8'hFF) begin
				fill_done_r <= 1'b1;
			end
		end
	end

	// Taps are the set time behind pwm_s3_r, one cycle when the set time is zero
	hbp_delay_mem u_dly (
		.clk_sys(clk_sys),
		.wr_addr(wr_ptr_r),
		.wr_data(pwm_s2_r),
		.rd_addr_a(wr_ptr_r - eff_delay(freewheel_crosscurrent_time_r)),
		.rd_addr_b(wr_ptr_r - eff_delay(active_crosscurrent_time_r)),
		.rd_data_a(dly_fw),
		.rd_data_b(dly_act)
	);

	////////////////////////////////////////////////////////////////////////
	// Gate commands for the PWM MOSFET and its opposite
	always_comb begin
		pwm_mos_on = 1'b0;
		opp_mos_on = 1'b0;
		pwm_mos_active = 1'b1;
		case (case_r)
			HBP_CASE_LOAD: begin
				pwm_mos_on = pwm_s3_r & dly_fw;
				opp_mos_on = ~pwm_s3_r & ~dly_act;
			end
			HBP_CASE_GEN: begin
				// Opposite MOSFET is active on the inverted PWM
				pwm_mos_active = 1'b0;
				opp_mos_on = ~pwm_s3_r & ~dly_fw;
				pwm_mos_on = pwm_s3_r & dly_act;
			end
			HBP_CASE_HIGH: begin
				pwm_mos_on = dly_fw;
				opp_mos_on = 1'b0;
			end
			HBP_CASE_LOW: begin
				pwm_mos_on = dly_act;
				opp_mos_on = 1'b0;
			end
			default: begin
				pwm_mos_on = 1'b0;
				opp_mos_on = 1'b0;
			end
		endcase
	end

	// Map onto high and low side; unknown mode keeps both off
	always_ff @(posedge clk_sys) begin
		if (rst || !fill_done_r) begin
			gate_hs_r <= 1'b0;
			gate_ls_r <= 1'b0;
		end else begin
			case (halfbridge_mode_select_r)
				HBP_MODE_HS_PWM: begin
					gate_hs_r <= pwm_mos_on;
					gate_ls_r <= opp_mos_on;
				end
				HBP_MODE_LS_PWM: begin
					gate_hs_r <= opp_mos_on;
					gate_ls_r <= pwm_mos_on;
				end
				default: begin
					gate_hs_r <= 1'b0;
					gate_ls_r <= 1'b0;
				end
			endcase
		end
	end

	// Registered current codes; active side gets active codes
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			hs_chg_r <= HBP_RST_CODE;
			hs_dchg_r <= HBP_RST_CODE;
			ls_chg_r <= HBP_RST_CODE;
			ls_dchg_r <= HBP_RST_CODE;
		end else if ((halfbridge_mode_select_r == HBP_MODE_HS_PWM) ==
			pwm_mos_active) begin
			hs_chg_r <= active_charge_code_r;
			hs_dchg_r <= active_discharge_code_r;
			ls_chg_r <= freewheel_charge_code_r;
			ls_dchg_r <= freewheel_discharge_code_r;
		end else begin
			hs_chg_r <= freewheel_charge_code_r;
			hs_dchg_r <= freewheel_discharge_code_r;
			ls_chg_r <= active_charge_code_r;
			ls_dchg_r <= active_discharge_code_r;
		end
	end

	assign gate_hs_on = gate_hs_r;
	assign gate_ls_on = gate_ls_r;
	assign hs_charge_code = hs_chg_r;
	assign hs_discharge_code = hs_dchg_r;
	assign ls_charge_code = ls_chg_r;
	assign ls_discharge_code = ls_dchg_r;
	assign precharge_initial_code = precharge_initial_code_r;
	assign predischarge_initial_code = predischarge_initial_code_r;

endmodule

// File: tb/hbp_pwm_src.sv
// PWM source and motor-state model for the controller's PWM input.
module hbp_pwm_src (
	input wire logic clk_sys,
	input wire logic run,
	input wire logic gen,
	input wire logic [15:0] on_c,
	input wire logic [15:0] off_c,
	output logic pwm_in,
	output logic generator_sense
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt = 0;
	initial pwm_in = 1'b0;
	initial generator_sense = 1'b0;
	////////////////////////////////////////////////////////////////////
	// Phase counter; new lengths apply at once, to the phase in progress
	always @(posedge clk_sys) begin
		generator_sense <= gen;
		if (!run) begin
			pwm_in <= 1'b0;
			cnt <= 0;
		end else if (cnt + 1 >= (pwm_in ? on_c : off_c)) begin
			pwm_in <= ~pwm_in;
			cnt <= 0;
		end else begin
			cnt <= cnt + 1;
		end
	end
endmodule

// File: tb/hbp_gate_ctrl_checker.sv
// Port-level assertions for the half-bridge gate controller.
module hbp_gate_ctrl_checker (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic gate_hs_on,
	input wire logic gate_ls_on,
	input wire logic [hbp_pkg::HBP_CODE_W-1:0] hs_charge_code,
	input wire logic [hbp_pkg::HBP_CODE_W-1:0] ls_discharge_code,
	input wire logic switch_timing_valid
);
	import hbp_pkg::*;
	logic unmapped;
	logic acc;
	// Decode kept apart so each property stays short
	assign unmapped = (paddr > 8'h24) || (paddr[1:0] != 2'h0);
	assign acc = psel && penable;
	////////////////////////////////////////////////////////////////////
	// Reset checks use the release edge, since rst itself disables
	a_gates_exclusive: assert property (@(posedge clk_sys) disable iff (rst)
		!(gate_hs_on && gate_ls_on)) else $error("both gates on");
	a_hs_fall_gap: assert property (@(posedge clk_sys) disable iff (rst)
		$fell(gate_hs_on) |-> !gate_ls_on [*2]) else $error("no dead time");
	a_reset_codes: assert property (@(posedge clk_sys) disable iff (rst)
		$fell(rst) |-> hs_charge_code == HBP_RST_CODE
		&& ls_discharge_code == HBP_RST_CODE) else $error("code reset");
	a_reset_gates_idle: assert property (@(posedge clk_sys) disable iff (rst)
		$fell(rst) |-> (!gate_hs_on && !gate_ls_on) [*8])
		else $error("gate on after reset");
	a_reset_invalid: assert property (@(posedge clk_sys) disable iff (rst)
		$fell(rst) |-> !switch_timing_valid) else $error("valid after reset");
	a_pready_access: assert property (@(posedge clk_sys) disable iff (rst)
		acc |-> pready) else $error("wait state seen");
	a_pready_idle: assert property (@(posedge clk_sys) disable iff (rst)
		!acc |-> !pready) else $error("stray ready");
	a_unmapped_err: assert property (@(posedge clk_sys) disable iff (rst)
		acc && unmapped |-> pslverr) else $error("no error flag");
	a_mapped_ok: assert property (@(posedge clk_sys) disable iff (rst)
		acc && !unmapped |-> !pslverr) else $error("false error flag");
	a_unmapped_zero: assert property (@(posedge clk_sys) disable iff (rst)
		acc && !pwrite && unmapped |-> prdata == 32'h0)
		else $error("unmapped read data");
endmodule

bind hbp_gate_ctrl hbp_gate_ctrl_checker u_chk (
	.clk_sys(clk_sys),
	.rst(rst),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.paddr(paddr),
	.prdata(prdata),
	.pready(pready),
	.pslverr(pslverr),
	.gate_hs_on(gate_hs_on),
	.gate_ls_on(gate_ls_on),
	.hs_charge_code(hs_charge_code),
	.ls_discharge_code(ls_discharge_code),
	.switch_timing_valid(switch_timing_valid)
);

// File: tb/hbp_gate_ctrl_tb_top.sv
// Self-checking bench for the half-bridge gate controller.
module hbp_gate_ctrl_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import hbp_pkg::*;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, pwm_in, generator_sense;
	logic gate_hs_on, gate_ls_on, switch_timing_valid;
	logic [HBP_CODE_W-1:0] hs_chg, hs_dchg, ls_chg, ls_dchg, pre_c, pre_d;
	logic run = 1'b0;
	logic gen = 1'b0;
	logic [15:0] on_c = 16'd50;
	logic [15:0] off_c = 16'd50;
	int fail_count = 0;
	int checks_done = 0;
	int seed = 13594;
	int cycles = 0;
	int fw_t = 20;
	int act_t = 30;
	////////////////////////////////////////////////////////////////////
	hbp_gate_ctrl dut (
		.clk_sys(clk_sys),
		.rst(rst),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.pwm_in(pwm_in),
		.generator_sense(generator_sense),
		.gate_hs_on(gate_hs_on),
		.gate_ls_on(gate_ls_on),
		.hs_charge_code(hs_chg),
		.hs_discharge_code(hs_dchg),
		.ls_charge_code(ls_chg),
		.ls_discharge_code(ls_dchg),
		.precharge_initial_code(pre_c),
		.predischarge_initial_code(pre_d),
		.switch_timing_valid(switch_timing_valid)
	);
	hbp_pwm_src u_src (
		.clk_sys(clk_sys),
		.run(run),
		.gen(gen),
		.on_c(on_c),
		.off_c(off_c),
		.pwm_in(pwm_in),
		.generator_sense(generator_sense)
	);
	////////////////////////////////////////////////////////////////////
	// Clock and cycle ceiling against a hung handshake
	always #20 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 60000) begin
			fail_count++;
			complete_run();
		end
	end
	task complete_run;
		if (fail_count == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t seen=%h expected=%h", $time, got, exp);
		end
	endtask
	// One APB transfer; request held until ready is sampled high
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		// No local limit: the cycle ceiling ends a hung wait
		do @(posedge clk_sys); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask
	function int rnd(int lo, int span);
		return lo + (($random(seed) & 32'h7FFF) % span);
	endfunction
	// Control case expected from the pwm phase lengths
	function logic [1:0] exp_case(int on, int off, logic g);
		if (off < act_t)
			return HBP_CASE_HIGH;
		if (on < fw_t)
			return HBP_CASE_LOW;
		if (g && off > fw_t && on > act_t)
			return HBP_CASE_GEN;
		return HBP_CASE_LOAD;
	endfunction
	// Delay from pwm rise to next gate rise, pulse width, opposite gate
	task meas(input logic ls, output int d, output int w, output int o);
		logic p;
		d = 0;
		w = 0;
		o = 0;
		p = 1'b1;
		do @(posedge clk_sys); while (pwm_in !== 1'b0);
		do @(posedge clk_sys); while (pwm_in !== 1'b1);
		// At high duty the gate is still on from the last period here
		while (((ls ? gate_ls_on : gate_hs_on) !== 1'b1 || p) && d < 300) begin
			p = (ls ? gate_ls_on : gate_hs_on) === 1'b1;
			@(posedge clk_sys);
			d++;
		end
		while ((ls ? gate_ls_on : gate_hs_on) === 1'b1 && w < 300) begin
			@(posedge clk_sys);
			w++;
		end
		repeat (150) begin
			@(posedge clk_sys);
			o += (ls ? gate_hs_on : gate_ls_on) === 1'b1;
		end
	endtask
	////////////////////////////////////////////////////////////////////
	// Main sequence: reset, both PWM modes and all cases, code scale, re-reset
	initial begin
		int m, k, d, w, o, ofs, on, off, i, pn;
		logic [31:0] q;
		logic e;
		logic [1:0] c;
		logic ls;
		logic [4:0] ac, ad, fc, fd, pc, pd;
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		chk(hs_chg, HBP_RST_CODE);
		chk(switch_timing_valid, 1'b0);
		ac = rnd(0, 32);
		ad = rnd(0, 32);
		fc = rnd(0, 32);
		fd = rnd(0, 32);
		pc = rnd(0, 32);
		pd = rnd(0, 32);
		wr(HBP_OFS_FW_TIME, fw_t);
		wr(HBP_OFS_ACT_TIME, act_t);
		wr(HBP_OFS_CTRL, 32'h1);
		wr(HBP_OFS_CHG, {19'h0, fd, 3'h0, fc});
		wr(HBP_OFS_CTRL, 32'h0);
		wr(HBP_OFS_CHG, ac);
		wr(HBP_OFS_DCHG, ad);
		wr(HBP_OFS_INIT, {19'h0, pd, 3'h0, pc});
		run <= 1'b1;
		ofs = 0;
		for (m = 1; m <= 2; m++) begin
			ls = (m == 2);
			for (k = 0; k < 4; k++) begin
				on = (k == 2) ? rnd(5, 10) : (k == 1) ? rnd(60, 40) : rnd(40, 20);
				off = (k == 1) ? rnd(5, 10) : (k == 2) ? rnd(60, 40) : rnd(40, 20);
				gen <= (k == 3);
				// Park both gates before swapping sides, else no dead time
				if (k == 0)
					wr(HBP_OFS_CTRL, 32'h0);
				wr(HBP_OFS_CTRL, (m << 2) | ((k == 3) << 1));
				on_c <= on;
				off_c <= off;
				repeat (3) meas(ls, d, w, o);
				apb(1'b0, HBP_OFS_STATUS, 32'h0, q, e);
				c = exp_case(on, off, k == 3);
				chk(q[1:0], c);
				chk(switch_timing_valid, c[1] == 1'b0);
				chk(ls ? ls_chg : hs_chg, (k == 3) ? fc : ac);
				chk(ls ? ls_dchg : hs_dchg, (k == 3) ? fd : ad);
				chk(ls ? hs_chg : ls_chg, (k == 3) ? ac : fc);
				chk(pre_d, pd);
				chk(pre_c, pc);
				if (k == 0 || k == 3)
					chk(o > 0, 1'b1);
				if (k == 1) begin
					chk(w, on);
					chk(o, 0);
					ofs = d - fw_t;
				end
				if (k == 2) begin
					chk(w, on);
					chk(o, 0);
					chk(d - act_t, ofs);
				end
			end
		end
		pn = 0;
		for (i = 0; i < 32; i++) begin
			wr(HBP_OFS_CHG, i);
			wr(HBP_OFS_DCHG, i);
			apb(1'b0, HBP_OFS_NOMINAL, 32'h0, q, e);
			if (i == 0)
				chk(q, {6'h0, 10'd10, 6'h0, 10'd10});
			else
				chk(q[9:0] > pn[9:0] && q[25:16] > pn[25:16], 1'b1);
			if (i == 31)
				chk(q, {6'h0, 10'd1000, 6'h0, 10'd1000});
			pn = q;
		end
		apb(1'b0, 8'h40, 32'h0, q, e);
		chk(e, 1'b1);
		chk(q, 32'h0);
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (2) @(posedge clk_sys);
		chk(ls_dchg, HBP_RST_CODE);
		complete_run();
	end
endmodule
